// >>> include/odm_cfg.svh
`ifndef ODM_CFG_SVH
`define ODM_CFG_SVH
// =====================================================
// register offsets
`define ODM_REG_OUT7_PRIM     8'h32
`define ODM_REG_OUT7_SEC      8'h33
`define ODM_REG_OUT7_GPO      8'h34
`define ODM_REG_OUT7_CROSS    8'h35
`define ODM_REG_OUT8_PRIM     8'h36
`define ODM_REG_OUT8_SEC      8'h37
`define ODM_REG_OUT8_GPO      8'h38
`define ODM_REG_OUT8_CROSS    8'h39
`define ODM_REG_MAN_ROUTE     8'h40
`define ODM_REG_POLARITY      8'h3A
`define ODM_REG_OUT6_STAGE    8'h31
// =====================================================
// reset values and field positions
`define ODM_RST_BYTE          8'h00
`define ODM_RDATA_NONE        8'h00
`define ODM_CROSS_BIT         0
`define ODM_TMO_LSB           1
`define ODM_STAGE_LSB         4
`define ODM_MAN_OUT7_BIT      6
`define ODM_MAN_OUT8_BIT      7
`define ODM_POL_OUT6_BIT      5
// =====================================================
// stage field codes
`define ODM_STG_OPEN_DRAIN    4'h0
`define ODM_STG_WEAK_BIAS     4'h5
`define ODM_STG_WEAK_FIRST    4'h1
`define ODM_STG_PP_FIRST      4'h6
`define ODM_STG_PP_LAST       4'h9
`define ODM_REF_BIAS          3'h0
// =====================================================
// timing, in ns, and clock rate
`define ODM_CLK_MHZ           200
`define ODM_TICK_NS           12500
`define ODM_TMO0_NS           25000
`define ODM_TMO1_NS           1562500
`define ODM_TMO2_NS           6250000
`define ODM_TMO3_NS           25000000
`define ODM_TMO4_NS           50000000
`define ODM_TMO5_NS           200000000
`define ODM_TMO6_NS           400000000
`define ODM_TMO7_NS           1600000000
`endif

// >>> include/odm_pkg.sv
package odm_pkg;
    // =====================================================
    // hold state, gray along idle-asserted-holding
    typedef enum logic [1:0] {
        ODM_IDLE     = 2'b00,
        ODM_ASSERTED = 2'b01,
        ODM_HOLDING  = 2'b11
    } odm_hold_state_t;
    // =====================================================
    // decoded output stage kind
    typedef enum logic [1:0] {
        ODM_STG_OFF  = 2'b00,
        ODM_STG_OD   = 2'b01,
        ODM_STG_WEAK = 2'b11,
        ODM_STG_PP   = 2'b10
    } odm_stage_kind_t;
endpackage

// >>> hw/odm_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module odm_sync2 #(
    parameter int         WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // =====================================================
    // first stage is read only by the second
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> hw/odm_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module odm_hold_timer #(
    parameter int CNT_W = 17
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_n_in,
    input  wire logic             tick_in,
    input  wire logic             cause_in,
    input  wire logic [CNT_W-1:0] limit_in,
    output logic                  asserted_out
);
    odm_pkg::odm_hold_state_t state_q;
    logic [CNT_W-1:0]         cnt_q;
    // =====================================================
    // state: assert on any cause, release after timeout
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= odm_pkg::ODM_IDLE;
        end else begin
            case (state_q)
                odm_pkg::ODM_IDLE: begin
                    if (cause_in) state_q <= odm_pkg::ODM_ASSERTED;
                end
                odm_pkg::ODM_ASSERTED: begin
                    if (!cause_in) state_q <= odm_pkg::ODM_HOLDING;
                end
                odm_pkg::ODM_HOLDING: begin
                    if (cause_in) state_q <= odm_pkg::ODM_ASSERTED;
                    else if (tick_in && cnt_q >= limit_in) state_q <= odm_pkg::ODM_IDLE;
                end
                default: state_q <= odm_pkg::ODM_IDLE;
            endcase
        end
    end
    // =====================================================
    // tick count; one extra tick covers the unknown first phase
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
        end else if (state_q != odm_pkg::ODM_HOLDING || cause_in) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end
    assign asserted_out = (state_q != odm_pkg::ODM_IDLE);
endmodule
`default_nettype wire

// >>> hw/odm_dependency_matrix.sv
`timescale 1ns/1ps
`default_nettype none
`include "odm_cfg.svh"
module odm_dependency_matrix #(
    parameter bit SIX_DETECTOR = 1'b1,
    parameter int TICK_CYCLES  = `ODM_TICK_NS * `ODM_CLK_MHZ / 1000
) (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] cfg_addr_in,
    input  wire logic       cfg_wr_in,
    input  wire logic [7:0] cfg_wdata_in,
    output logic      [7:0] cfg_rdata_out,
    input  wire logic [5:0] detector_primary_in,
    input  wire logic [5:0] detector_secondary_in,
    input  wire logic [1:0] watchdog_fault_in,
    input  wire logic [3:0] logic_in_in,
    input  wire logic       manual_reset_low_n_in,
    input  wire logic [4:0] prog_out_one_five_in,
    input  wire logic [1:0] prog_out_six_product_in,
    output logic      [2:0] po_asserted_out,
    output logic      [2:0] po_level_out,
    output logic      [2:0] po_oe_out,
    output logic      [2:0] po_pullup_out,
    output logic      [8:0] po_ref_out
);
    // =====================================================
    // register storage, indexed
    localparam int REG_N = 11;
    localparam int IDX_O7 = 0;
    localparam int IDX_O8 = 4;
    localparam int IDX_MAN = 8;
    localparam int IDX_POL = 9;
    localparam int IDX_O6 = 10;
    logic [7:0] regs_q [REG_N];

    function automatic logic [4:0] reg_index(input logic [7:0] addr);
        if (addr == `ODM_REG_OUT7_PRIM) reg_index = {1'b1, 4'd0};
        else if (addr == `ODM_REG_OUT7_SEC) reg_index = {1'b1, 4'd1};
        else if (addr == `ODM_REG_OUT7_GPO) reg_index = {1'b1, 4'd2};
        else if (addr == `ODM_REG_OUT7_CROSS) reg_index = {1'b1, 4'd3};
        else if (addr == `ODM_REG_OUT8_PRIM) reg_index = {1'b1, 4'd4};
        else if (addr == `ODM_REG_OUT8_SEC) reg_index = {1'b1, 4'd5};
        else if (addr == `ODM_REG_OUT8_GPO) reg_index = {1'b1, 4'd6};
        else if (addr == `ODM_REG_OUT8_CROSS) reg_index = {1'b1, 4'd7};
        else if (addr == `ODM_REG_MAN_ROUTE) reg_index = {1'b1, 4'd8};
        else if (addr == `ODM_REG_POLARITY) reg_index = {1'b1, 4'd9};
        else if (addr == `ODM_REG_OUT6_STAGE) reg_index = {1'b1, 4'd10};
        else reg_index = 5'h0_0;
    endfunction

    logic [4:0] wr_hit;
    logic [4:0] rd_hit;
    assign wr_hit = reg_index(cfg_addr_in);
    assign rd_hit = wr_hit;

    // =====================================================
    // register write port
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < REG_N; i++) begin
                regs_q[i] <= `ODM_RST_BYTE;
            end
        end else if (cfg_wr_in && wr_hit[4]) begin
            regs_q[wr_hit[3:0]] <= cfg_wdata_in;
        end
    end

    // =====================================================
    // register read port, one cycle latency
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_rdata_out <= `ODM_RDATA_NONE;
        end else if (rd_hit[4]) begin
            cfg_rdata_out <= regs_q[rd_hit[3:0]];
        end else begin
            cfg_rdata_out <= `ODM_RDATA_NONE;
        end
    end

    // =====================================================
    // detector, logic and manual reset inputs through two flops; watchdog faults go straight in
    logic [16:0] pin_sync;
    logic [5:0]  prim_s;
    logic [5:0]  sec_s;
    logic [3:0]  gpi_s;
    logic        man_low_n_s;
    odm_sync2 #(
        .WIDTH   (17),
        .RST_VAL (17'h1_0000)
    ) u_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({manual_reset_low_n_in, logic_in_in, detector_secondary_in, detector_primary_in}),
        .sync_out   (pin_sync)
    );
    assign prim_s     = pin_sync[5:0];
    assign sec_s      = pin_sync[11:6];
    assign gpi_s      = pin_sync[15:12];
    assign man_low_n_s = pin_sync[16];

    // =====================================================
    // timeout tick divider; slow rate as one-cycle enable
    logic [15:0] div_q;
    logic        tick_q;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == 16'(TICK_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    function automatic logic [16:0] tmo_ticks(input logic [2:0] code);
        case (code)
            3'd0: tmo_ticks = 17'(`ODM_TMO0_NS / `ODM_TICK_NS);
            3'd1: tmo_ticks = 17'(`ODM_TMO1_NS / `ODM_TICK_NS);
            3'd2: tmo_ticks = 17'(`ODM_TMO2_NS / `ODM_TICK_NS);
            3'd3: tmo_ticks = 17'(`ODM_TMO3_NS / `ODM_TICK_NS);
            3'd4: tmo_ticks = 17'(`ODM_TMO4_NS / `ODM_TICK_NS);
            3'd5: tmo_ticks = 17'(`ODM_TMO5_NS / `ODM_TICK_NS);
            3'd6: tmo_ticks = 17'(`ODM_TMO6_NS / `ODM_TICK_NS);
            default: tmo_ticks = 17'(`ODM_TMO7_NS / `ODM_TICK_NS);
        endcase
    endfunction

    // =====================================================
    // absent resources on the four-detector variant
    // absent enables masked
    localparam logic [23:0] AVAIL = SIX_DETECTOR ? 24'hFF_FFFF : 24'hF3_CFCF;

    function automatic logic dep_hit(input logic [23:0] mask, input logic [23:0] src,
                                     input logic cross_en, input logic cross_src,
                                     input logic mr_en, input logic mr_low);
        dep_hit = |(mask & src & AVAIL) | (cross_en & cross_src) | (mr_en & mr_low);
    endfunction

    // =====================================================
    // source vector, byte by byte as the masks lay out
    logic [2:0]  hold_asserted;
    logic [23:0] src_vec;
    logic [5:0]  outs_one_six;
    assign outs_one_six = {hold_asserted[0], prog_out_one_five_in};
    assign src_vec[7:0]   = {watchdog_fault_in, prim_s};
    assign src_vec[15:8]  = {gpi_s[1:0], sec_s};
    assign src_vec[23:16] = {outs_one_six, gpi_s[3:2]};

    logic [2:0] cause;
    assign cause[0] = ~(prog_out_six_product_in[0] | prog_out_six_product_in[1]);
    assign cause[1] = dep_hit({regs_q[IDX_O7 + 2], regs_q[IDX_O7 + 1], regs_q[IDX_O7]}, src_vec,
                              regs_q[IDX_O7 + 3][`ODM_CROSS_BIT] & SIX_DETECTOR, hold_asserted[2],
                              regs_q[IDX_MAN][`ODM_MAN_OUT7_BIT], ~man_low_n_s);
    assign cause[2] = SIX_DETECTOR &
                      dep_hit({regs_q[IDX_O8 + 2], regs_q[IDX_O8 + 1], regs_q[IDX_O8]}, src_vec,
                              regs_q[IDX_O8 + 3][`ODM_CROSS_BIT], hold_asserted[1],
                              regs_q[IDX_MAN][`ODM_MAN_OUT8_BIT], ~man_low_n_s);

    // =====================================================
    // stage decode; this wide field has no charge-pump code
    // stage code meanings
    function automatic logic [4:0] stage_decode(input logic [3:0] code);
        logic [2:0] ref_sel;
        ref_sel = `ODM_REF_BIAS;
        if (code == `ODM_STG_OPEN_DRAIN) begin
            stage_decode = {odm_pkg::ODM_STG_OD, ref_sel};
        end else if (code == `ODM_STG_WEAK_BIAS) begin
            stage_decode = {odm_pkg::ODM_STG_WEAK, ref_sel};
        end else if (code < `ODM_STG_WEAK_BIAS) begin
            ref_sel = 3'(code - `ODM_STG_WEAK_FIRST) + 3'h1;
            stage_decode = {odm_pkg::ODM_STG_WEAK, ref_sel};
        end else if (code <= `ODM_STG_PP_LAST) begin
            ref_sel = 3'(code - `ODM_STG_PP_FIRST) + 3'h1;
            stage_decode = {odm_pkg::ODM_STG_PP, ref_sel};
        end else begin
            stage_decode = {odm_pkg::ODM_STG_OFF, ref_sel};
        end
    endfunction

    // =====================================================
    // per-output timer and pin stage
    localparam int STAGE_IDX [3] = '{IDX_O6, IDX_O7 + 3, IDX_O8 + 3};
    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_out
            logic [7:0]                cfg_b;
            logic [4:0]                dec;
            odm_pkg::odm_stage_kind_t  kind;
            logic [2:0]                ref_sel;
            logic                      pol;
            logic                      lvl;
            logic                      ref_absent;
            assign cfg_b = regs_q[STAGE_IDX[k]];
            assign dec     = stage_decode(cfg_b[`ODM_STAGE_LSB +: 4]);
            assign kind    = odm_pkg::odm_stage_kind_t'(dec[4:3]);
            assign ref_sel = dec[2:0];
            // refs to missing detectors are unusable
            assign ref_absent = !SIX_DETECTOR && ref_sel > 3'h2;
            assign pol = regs_q[IDX_POL][`ODM_POL_OUT6_BIT + k];
            odm_hold_timer #(
                .CNT_W (17)
            ) u_hold (
                .mclk_in      (mclk_in),
                .reset_n_in   (reset_n_in),
                .tick_in      (tick_q),
                .cause_in     (cause[k]),
                .limit_in     (tmo_ticks(cfg_b[`ODM_TMO_LSB +: 3])),
                .asserted_out (hold_asserted[k])
            );
            assign lvl = hold_asserted[k] ? pol : ~pol;
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    po_asserted_out[k] <= 1'b0;
                    po_level_out[k]    <= 1'b0;
                end else begin
                    po_asserted_out[k] <= hold_asserted[k];
                    po_level_out[k]    <= lvl;
                end
            end
            // open drain and weak pull low only; unused stays off
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    po_oe_out[k]         <= 1'b0;
                    po_pullup_out[k]     <= 1'b0;
                    po_ref_out[3*k +: 3] <= `ODM_REF_BIAS;
                end else if (ref_absent) begin
                    po_oe_out[k]         <= 1'b0;
                    po_pullup_out[k]     <= 1'b0;
                    po_ref_out[3*k +: 3] <= `ODM_REF_BIAS;
                end else begin
                    case (kind)
                        odm_pkg::ODM_STG_PP:   po_oe_out[k] <= 1'b1;
                        odm_pkg::ODM_STG_OD:   po_oe_out[k] <= ~lvl;
                        odm_pkg::ODM_STG_WEAK: po_oe_out[k] <= ~lvl;
                        default:               po_oe_out[k] <= 1'b0;
                    endcase
                    po_pullup_out[k]     <= (kind == odm_pkg::ODM_STG_WEAK);
                    po_ref_out[3*k +: 3] <= ref_sel;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> test/odm_dependency_matrix_props.sv
`timescale 1ns/1ps
`default_nettype none
module odm_dependency_matrix_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic       cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic [7:0] cfg_rdata_out,
    input wire logic [1:0] watchdog_fault_in,
    input wire logic       manual_reset_low_n_in,
    input wire logic [1:0] prog_out_six_product_in,
    input wire logic [2:0] po_asserted_out,
    input wire logic [2:0] po_level_out,
    input wire logic [2:0] po_oe_out,
    input wire logic [8:0] po_ref_out
);
    // ========================================
    // shadows of the configuration the rules read
    logic [7:0] m32_q, m36_q, c35_q, c39_q, pol_q, man_q;
    logic [1:0] up_q;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {m32_q, m36_q, c35_q, c39_q, pol_q, man_q} <= 48'h0000_0000_0000;
        end else if (cfg_wr_in) begin
            case (cfg_addr_in)
                8'h32: m32_q <= cfg_wdata_in;
                8'h35: c35_q <= cfg_wdata_in;
                8'h36: m36_q <= cfg_wdata_in;
                8'h39: c39_q <= cfg_wdata_in;
                8'h3A: pol_q <= cfg_wdata_in;
                8'h40: man_q <= cfg_wdata_in;
                default: ;
            endcase
        end
    end
    // level checks wait until idle levels settle
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    // ========================================
    // properties
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_wr_held;
        cfg_wr_in && cfg_addr_in inside {[8'h32:8'h39]} ##1 !cfg_wr_in && $stable(cfg_addr_in) ##1 $stable(cfg_addr_in);
    endsequence
    sequence s_man7;
        (!manual_reset_low_n_in && man_q[6]) [*5];
    endsequence
    sequence s_man8;
        (!manual_reset_low_n_in && man_q[7]) [*5];
    endsequence
    a_unmapped_reads_zero: assert property (!(cfg_addr_in inside {[8'h31:8'h3A], 8'h40}) |=> cfg_rdata_out == 8'h00)
        else $error("unmapped address read nonzero");
    a_mask_readback: assert property (s_wr_held |-> cfg_rdata_out == $past(cfg_wdata_in, 2))
        else $error("mask byte did not read back");
    a_wd_out_seven: assert property (watchdog_fault_in[0] && m32_q[6] |-> ##2 po_asserted_out[1])
        else $error("watchdog one did not assert output seven");
    a_wd_out_eight: assert property (watchdog_fault_in[1] && m36_q[7] |-> ##2 po_asserted_out[2])
        else $error("watchdog two did not assert output eight");
    a_cross_seven: assert property (po_asserted_out[2] && $past(c35_q[0]) |=> po_asserted_out[1])
        else $error("output seven ignored output eight");
    a_cross_eight: assert property (po_asserted_out[1] && $past(c39_q[0]) |=> po_asserted_out[2])
        else $error("output eight ignored output seven");
    a_man_seven: assert property (s_man7 |-> po_asserted_out[1])
        else $error("manual reset did not assert output seven");
    a_man_eight: assert property (s_man8 |-> po_asserted_out[2])
        else $error("manual reset did not assert output eight");
    a_out6_products: assert property (prog_out_six_product_in == 2'b00 |-> ##2 po_asserted_out[0])
        else $error("output six not asserted with both terms low");
    a_polarity_level: assert property (up_q == 2'h3 |-> po_level_out == (po_asserted_out ~^ $past(pol_q[7:5])))
        else $error("pin level disagrees with polarity");
    a_push_pull_drive: assert property ($past(c35_q[7:4]) inside {[4'h6:4'h9]}
        |-> po_oe_out[1] && po_ref_out[5:3] == 3'($past(c35_q[7:4]) - 4'h5)) else $error("push-pull stage wrong");
    a_unused_stage_off: assert property ($past(c35_q[7:4]) >= 4'hA |-> !po_oe_out[1])
        else $error("unused stage code drives pin");
    a_open_drain_oe: assert property (up_q == 2'h3 && $past(c35_q[7:4]) <= 4'h5
        |-> po_oe_out[1] == !po_level_out[1]) else $error("open-drain stage drives high");
endmodule
bind odm_dependency_matrix odm_dependency_matrix_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .watchdog_fault_in(watchdog_fault_in),
    .manual_reset_low_n_in(manual_reset_low_n_in), .prog_out_six_product_in(prog_out_six_product_in),
    .po_asserted_out(po_asserted_out), .po_level_out(po_level_out), .po_oe_out(po_oe_out),
    .po_ref_out(po_ref_out)
);
`default_nettype wire

// >>> test/odm_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module odm_load_model (
    input  wire logic level_in,
    input  wire logic oe_in,
    output logic      pin_out
);
    // released line pulls up
    // a board pull-up sits on the one loaded output (output seven in the bench), so a released pin never floats
    assign pin_out = oe_in ? level_in : 1'b1;
endmodule
`default_nettype wire

// >>> test/odm_dependency_matrix_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odm_dependency_matrix_tb;
    localparam int TICK = 4;
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  cfg_addr_in = 8'h00;
    logic        cfg_wr_in = 1'b0;
    logic [7:0]  cfg_wdata_in = 8'h00;
    logic [23:0] src_q = 24'h00_0000;
    logic        man_n_q = 1'b1;
    logic        prod_q = 1'b0;
    logic [7:0]  cfg_rdata_out;
    logic [2:0]  po_asserted_out, po_level_out, po_oe_out, po_pullup_out;
    logic [8:0]  po_ref_out;
    logic        pin7;
    int          errors = 0;
    int          total_checks = 0;
    always #2.5 mclk_in = ~mclk_in;
    // ========================================
    // design and load
    odm_dependency_matrix #(.SIX_DETECTOR(1'b1), .TICK_CYCLES(TICK)) uut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in),
        .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out), .detector_primary_in(src_q[5:0]),
        .detector_secondary_in(src_q[13:8]), .watchdog_fault_in(src_q[7:6]), .logic_in_in(src_q[17:14]),
        .manual_reset_low_n_in(man_n_q), .prog_out_one_five_in(src_q[22:18]),
        .prog_out_six_product_in({prod_q, ~src_q[23]}), .po_asserted_out(po_asserted_out),
        .po_level_out(po_level_out), .po_oe_out(po_oe_out), .po_pullup_out(po_pullup_out), .po_ref_out(po_ref_out));
    odm_load_model u_load (.level_in(po_level_out[1]), .oe_in(po_oe_out[1]), .pin_out(pin7));
    // ========================================
    // shared tasks
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        cfg_addr_in <= a;
        cfg_wr_in <= 1'b1;
        cfg_wdata_in <= d;
        @(posedge mclk_in);
        cfg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        cfg_addr_in <= a;
        @(posedge mclk_in);
        #1 d = cfg_rdata_out;
    endtask
    task automatic put_src(input logic [23:0] v);
        @(posedge mclk_in);
        src_q <= v;
    endtask
    task automatic wait_po(input int sel, input logic val, input int limit, output int n);
        n = 0;
        #1;
        while (po_asserted_out[sel] !== val && n < limit) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] addrs [12] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h40, 8'h41};
        logic [7:0] d;
        foreach (addrs[k]) begin
            rd(addrs[k], d);
            check_byte("reset value", 8'h00, d);
            wr(addrs[k], addrs[k] ^ 8'hA5);
            rd(addrs[k], d);
            check_byte("readback", (addrs[k] == 8'h41) ? 8'h00 : addrs[k] ^ 8'hA5, d);
            wr(addrs[k], 8'h00);
        end
        $display("test registers done");
    endtask
    task automatic t_mask(input int sel, input logic [7:0] base);
        int n;
        for (int i = 0; i < 24; i++) begin
            for (int b = 0; b < 3; b++) begin
                wr(base + 8'(b), (i / 8 == b) ? 8'(1 << (i % 8)) : 8'h00);
            end
            put_src(24'(1) << i);
            wait_po(sel, 1'b1, 12, n);
            check_byte("source asserts", 8'h01, 8'(po_asserted_out[sel]));
            put_src(24'h00_0000);
            wait_po(sel, 1'b0, 60, n);
            check_byte("hold span", 8'h01, 8'(n >= 2 * TICK && n <= ((i == 23) ? 50 : 26)));
            wr(base + 8'(i / 8), 8'h00);
            put_src(24'(1) << i);
            repeat (10) @(posedge mclk_in);
            #1 check_byte("masked source", 8'h00, 8'(po_asserted_out[sel]));
            put_src(24'h00_0000);
        end
        repeat (40) @(posedge mclk_in);
        $display("test masks of output %0d done", sel + 6);
    endtask
    task automatic t_cross();
        int n;
        prod_q <= 1'b1;
        put_src(24'h80_0000);
        repeat (6) @(posedge mclk_in);
        #1 check_byte("product two", 8'h00, {5'h00, po_asserted_out});
        put_src(24'h00_0000);
        prod_q <= 1'b0;
        wr(8'h36, 8'h80);
        wr(8'h35, 8'h01);
        put_src(24'h00_0080);
        wait_po(1, 1'b1, 12, n);
        check_byte("seven through eight", 8'h06, {5'h00, po_asserted_out});
        put_src(24'h00_0000);
        wait_po(1, 1'b0, 80, n);
        wr(8'h35, 8'h00);
        wr(8'h36, 8'h00);
        wr(8'h32, 8'h40);
        wr(8'h39, 8'h01);
        put_src(24'h00_0040);
        wait_po(2, 1'b1, 12, n);
        check_byte("eight through seven", 8'h06, {5'h00, po_asserted_out});
        put_src(24'h00_0000);
        wait_po(2, 1'b0, 80, n);
        wr(8'h32, 8'h00);
        wr(8'h39, 8'h00);
        $display("test cross dependency done");
    endtask
    task automatic t_man(input logic [7:0] route, input logic [7:0] exp);
        int n;
        wr(8'h40, route);
        @(posedge mclk_in);
        man_n_q <= 1'b0;
        repeat (8) @(posedge mclk_in);
        #1 check_byte("manual reset", exp, {5'h00, po_asserted_out});
        @(posedge mclk_in);
        man_n_q <= 1'b1;
        wait_po((exp == 8'h04) ? 2 : 1, 1'b0, 60, n);
        wr(8'h40, 8'h00);
        $display("test manual reset route %h done", route);
    endtask
    task automatic t_timeout();
        int n;
        wr(8'h32, 8'h40);
        wr(8'h35, 8'h02);
        put_src(24'h00_0040);
        wait_po(1, 1'b1, 12, n);
        put_src(24'h00_0000);
        wait_po(1, 1'b0, 700, n);
        check_byte("long hold", 8'h01, 8'(n >= 125 * TICK && n <= 127 * TICK + 8));
        wr(8'h32, 8'h00);
        wr(8'h35, 8'h00);
        $display("test timeout done");
    endtask
    task automatic t_stage();
        logic [3:0] c;
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            wr(8'h35, {c, 4'h0});
            repeat (3) @(posedge mclk_in);
            #1 check_byte("drive enable", 8'(c inside {[4'h6:4'h9]}), 8'(po_oe_out[1]));
            check_byte("pullup", 8'(c inside {[4'h1:4'h5]}), 8'(po_pullup_out[1]));
            if (c >= 4'h1 && c <= 4'h9) begin
                check_byte("reference", 8'((c == 4'h5) ? 4'h0 : (c >= 4'h6) ? c - 4'h5 : c), 8'(po_ref_out[5:3]));
            end
        end
        wr(8'h35, 8'h00);
        wr(8'h3A, 8'h40);
        repeat (3) @(posedge mclk_in);
        #1 check_byte("idle pin active high", 8'h00, {7'h00, pin7});
        wr(8'h3A, 8'h00);
        repeat (3) @(posedge mclk_in);
        #1 check_byte("idle pin active low", 8'h01, {7'h00, pin7});
        $display("test stages done");
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_mask(1, 8'h32);
        t_mask(2, 8'h36);
        t_cross();
        t_man(8'h40, 8'h02);
        t_man(8'h80, 8'h04);
        t_man(8'h00, 8'h00);
        t_timeout();
        t_stage();
        give_verdict();
    end
    initial begin
        #100000;
        errors++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule
`default_nettype wire
